//--- design/aocm_pkg.sv
// constants, register map and field layout of the calibration block
package aocm_pkg;
	localparam int unsigned DATA_W   = 24;
	localparam int unsigned GAIN_W   = 16;
	localparam int unsigned AXI_AW   = 8;
	localparam int unsigned AXI_DW   = 32;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned WORD_SH  = 2;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_STATUS   = 6'h00;
	localparam logic [5:0] IDX_CONFIG   = 6'h01;
	localparam logic [5:0] IDX_OFS_LOW  = 6'h02;
	localparam logic [5:0] IDX_OFS_MID  = 6'h03;
	localparam logic [5:0] IDX_OFS_HIGH = 6'h04;
	localparam logic [5:0] IDX_GAIN_LOW = 6'h05;
	localparam logic [5:0] IDX_GAIN_HI  = 6'h06;
	localparam logic [5:0] IDX_RESULT   = 6'h07;

	// configuration and status fields
	localparam int unsigned CFG_OFS_EN_BIT  = 5;
	localparam int unsigned CFG_GAIN_EN_BIT = 4;
	localparam int unsigned ST_RANGE_BIT    = 0;
	localparam int unsigned ST_SPI_BIT      = 1;
	localparam int unsigned ST_HIRES_BIT    = 2;
	localparam int unsigned ST_CLK_OK_BIT   = 3;

	// reset values: neutral correction
	localparam logic [7:0]        CONFIG_RST = 8'h00;
	localparam logic [DATA_W-1:0] OFS_RST    = 24'h000000;
	localparam logic [GAIN_W-1:0] GAIN_RST   = 16'h8000;
	localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h8000;
	localparam int unsigned       GAIN_SHIFT = 15;

	localparam logic [DATA_W-1:0] SAT_POS = 24'h7FFFFF;
	localparam logic [DATA_W-1:0] SAT_NEG = 24'h800000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// clock figures in hertz
	localparam longint CLK_HZ      = 20_000_000;
	localparam longint CLK_MIN_HZ  = 100_000;
	localparam longint HIRES_MAX_HZ = 17_600_000;
	localparam longint LOWPWR_MAX_HZ = 8_800_000;
endpackage

//--- design/aocm_top.sv
// offset/gain correction, clipping, out-of-range flag and register slave
// Function
// - subtract offset, multiply gain, divide 8000h
// - saturate corrected result to 24-bit signed
// - offset word from bytes 02h,03h,04h
// - offset two's complement; zero means unchanged
// - gain word from bytes 05h and 06h
// - gain 8000h unity, 0000h gives zero
// - offset applied only when config bit5 set
// - gain applied only when config bit4 set
// - correction path only in SPI interface mode
// - no self-calibration; host values only
// - out-of-range flag accompanies each affected result
// - flag from comparator, no filter latency
// - filter clocked directly, no prescaler
// - data rate scales with clock, min 100kHz
// - high pin hi-res 17.6MHz, low 8.8MHz
// - format pin low SPI, high frame-sync
module aocm_top
	import aocm_pkg::*;
(
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [aocm_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [aocm_pkg::AXI_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [aocm_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [aocm_pkg::AXI_DW-1:0]      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic [aocm_pkg::DATA_W-1:0] filt_data,
	input  wire logic                        filt_valid,
	input  wire logic                        input_over_range,
	input  wire logic                        resolution_mode_select,
	input  wire logic                        format_select,
	output logic [aocm_pkg::DATA_W-1:0]      out_data,
	output logic                             out_valid,
	output logic                             input_out_of_range_flag,
	output logic                             high_res_mode,
	output logic                             clk_in_range
);
	import aocm_pkg::*;

	// control registers
	logic [7:0]        config_reg;
	logic [BYTE_W-1:0] offset_corr_low_byte;
	logic [BYTE_W-1:0] offset_corr_mid_byte;
	logic [BYTE_W-1:0] offset_corr_high_byte;
	logic [BYTE_W-1:0] gain_corr_low_byte;
	logic [BYTE_W-1:0] gain_corr_high_byte;
	logic [DATA_W-1:0] offset_correction_word;
	logic [GAIN_W-1:0] gain_correction_word;

	// write channel holding
	logic              aw_held;
	logic              w_held;
	logic [5:0]        aw_idx;
	logic [AXI_DW-1:0] w_data;
	logic [3:0]        w_strb;
	logic              do_write;
	logic              wr_mapped;

	// offset and gain words are only what software wrote
	assign offset_correction_word = {offset_corr_high_byte, offset_corr_mid_byte,
		offset_corr_low_byte};
	assign gain_correction_word = {gain_corr_high_byte, gain_corr_low_byte};

	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_mapped = (aw_idx >= IDX_CONFIG) && (aw_idx <= IDX_GAIN_HI);

	// address and data accepted independently
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			aw_idx        <= 6'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_idx  <= s_axi_awaddr[WORD_SH+5:WORD_SH];
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held       <= 1'b0;
			w_data       <= '0;
			w_strb       <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register storage, byte lane 0 carries each 8-bit register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			config_reg            <= CONFIG_RST;
			offset_corr_low_byte  <= OFS_RST[7:0];
			offset_corr_mid_byte  <= OFS_RST[15:8];
			offset_corr_high_byte <= OFS_RST[23:16];
			gain_corr_low_byte    <= GAIN_RST[7:0];
			gain_corr_high_byte   <= GAIN_RST[15:8];
		end else if (do_write && w_strb[0]) begin
			case (aw_idx)
				IDX_CONFIG:   config_reg            <= w_data[7:0];
				IDX_OFS_LOW:  offset_corr_low_byte  <= w_data[7:0];
				IDX_OFS_MID:  offset_corr_mid_byte  <= w_data[7:0];
				IDX_OFS_HIGH: offset_corr_high_byte <= w_data[7:0];
				IDX_GAIN_LOW: gain_corr_low_byte    <= w_data[7:0];
				IDX_GAIN_HI:  gain_corr_high_byte   <= w_data[7:0];
				default: begin
				end
			endcase
		end
	end

	// correction datapath
	logic                     spi_mode;
	logic                     ofs_active;
	logic                     gain_active;
	logic signed [DATA_W:0]   diff;
	logic signed [DATA_W:0]   next_diff;
	logic                     diff_valid;
	logic                     diff_range;
	logic                     range_acc;
	logic [GAIN_W-1:0]        gain_used;
	logic [GAIN_W-1:0]        diff_gain;
	logic signed [DATA_W+GAIN_W+1:0] product;
	logic signed [DATA_W+GAIN_W+1:0] scaled;
	logic [DATA_W-1:0]        next_out;
	logic                     last_range;

	assign spi_mode    = !format_select;
	assign ofs_active  = config_reg[CFG_OFS_EN_BIT] && spi_mode;
	assign gain_active = config_reg[CFG_GAIN_EN_BIT] && spi_mode;

	// two's complement offset, zero word subtracts nothing
	assign next_diff = ofs_active
		? $signed({filt_data[DATA_W-1], filt_data})
			- $signed({offset_correction_word[DATA_W-1], offset_correction_word})
		: $signed({filt_data[DATA_W-1], filt_data});

	// gain word as unsigned fraction of 8000h
	assign gain_used = gain_active ? gain_correction_word : GAIN_UNITY;
	assign product = diff * $signed({1'b0, diff_gain});
	assign scaled  = product >>> GAIN_SHIFT;

	// clip to 24-bit signed range
	always_comb begin
		if (scaled > $signed({{(GAIN_W+2){1'b0}}, SAT_POS})) begin
			next_out = SAT_POS;
		end else if (scaled < $signed({{(GAIN_W+2){1'b1}}, SAT_NEG})) begin
			next_out = SAT_NEG;
		end else begin
			next_out = scaled[DATA_W-1:0];
		end
	end

	// comparator events since the last result, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			range_acc <= 1'b0;
		end else if (filt_valid) begin
			range_acc <= input_over_range;
		end else begin
			range_acc <= range_acc | input_over_range;
		end
	end

	// first stage: offset, gain word frozen with its sample; runs on aclk, no divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			diff       <= '0;
			diff_gain  <= GAIN_UNITY;
			diff_valid <= 1'b0;
			diff_range <= 1'b0;
		end else begin
			diff_valid <= filt_valid;
			if (filt_valid) begin
				diff       <= next_diff;
				diff_gain  <= gain_used;
				diff_range <= range_acc | input_over_range;
			end
		end
	end

	// second stage: gain, clip, present
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_data                <= '0;
			out_valid               <= 1'b0;
			input_out_of_range_flag <= 1'b0;
			last_range              <= 1'b0;
		end else begin
			out_valid <= diff_valid;
			if (diff_valid) begin
				out_data                <= next_out;
				input_out_of_range_flag <= diff_range;
				last_range              <= diff_range;
			end
		end
	end

	// operating mode and clock limit from the mode pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_res_mode <= 1'b0;
			clk_in_range  <= 1'b0;
		end else begin
			high_res_mode <= resolution_mode_select;
			clk_in_range  <= (CLK_HZ >= CLK_MIN_HZ) && (resolution_mode_select
				? (CLK_HZ <= HIRES_MAX_HZ) : (CLK_HZ <= LOWPWR_MAX_HZ));
		end
	end

	// read channel
	logic [5:0]        ar_idx;
	logic [AXI_DW-1:0] next_rdata;
	logic              rd_mapped;

	assign ar_idx = s_axi_araddr[WORD_SH+5:WORD_SH];

	always_comb begin
		next_rdata = '0;
		rd_mapped  = 1'b1;
		case (ar_idx)
			IDX_STATUS: begin
				next_rdata[ST_RANGE_BIT]  = last_range;
				next_rdata[ST_SPI_BIT]    = spi_mode;
				next_rdata[ST_HIRES_BIT]  = high_res_mode;
				next_rdata[ST_CLK_OK_BIT] = clk_in_range;
			end
			IDX_CONFIG:   next_rdata[7:0] = config_reg;
			IDX_OFS_LOW:  next_rdata[7:0] = offset_corr_low_byte;
			IDX_OFS_MID:  next_rdata[7:0] = offset_corr_mid_byte;
			IDX_OFS_HIGH: next_rdata[7:0] = offset_corr_high_byte;
			IDX_GAIN_LOW: next_rdata[7:0] = gain_corr_low_byte;
			IDX_GAIN_HI:  next_rdata[7:0] = gain_corr_high_byte;
			IDX_RESULT:   next_rdata[DATA_W-1:0] = out_data;
			default:      rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid
				? 1'b1 : (!s_axi_rvalid && !s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= next_rdata;
				s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

//--- verification/aocm_host.sv
// host model: register bus master and gain arithmetic
module aocm_host (
	input  logic        aclk,
	output logic [7:0]  s_axi_awaddr,
	output logic        s_axi_awvalid,
	input  logic        s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0]  s_axi_wstrb,
	output logic        s_axi_wvalid,
	input  logic        s_axi_wready,
	input  logic [1:0]  s_axi_bresp,
	input  logic        s_axi_bvalid,
	output logic        s_axi_bready,
	output logic [7:0]  s_axi_araddr,
	output logic        s_axi_arvalid,
	input  logic        s_axi_arready,
	input  logic [31:0] s_axi_rdata,
	input  logic [1:0]  s_axi_rresp,
	input  logic        s_axi_rvalid,
	output logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	task automatic wr(input logic [5:0] i, input logic [31:0] d, output logic [1:0] r);
		logic a;
		logic w;
		a = 0;
		w = 0;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(a && w)) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			a |= s_axi_awready;
			w |= s_axi_wready;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	function automatic logic [15:0] gain_for(input logic [23:0] e, input logic [23:0] a);
		return 16'((32'(e) << 15) / 32'(a));
	endfunction
	// mean of two shorted-input codes, written back as offset
	function automatic logic [23:0] ofs_avg(input logic [23:0] p, input logic [23:0] q);
		return 24'(($signed({p[23], p}) + $signed({q[23], q})) >>> 1);
	endfunction
endmodule

//--- verification/aocm_top_properties.sv
// checker of result timing, hold and mode outputs
module aocm_top_chk (
	input logic        aclk,
	input logic        aresetn,
	input logic [23:0] filt_data,
	input logic        filt_valid,
	input logic        input_over_range,
	input logic        resolution_mode_select,
	input logic        format_select,
	input logic [23:0] out_data,
	input logic        out_valid,
	input logic        input_out_of_range_flag,
	input logic        high_res_mode,
	input logic        clk_in_range,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	result_latency_a: assert property (filt_valid |-> ##2 out_valid)
		else $error("result late");
	no_spurious_a: assert property (out_valid |-> $past(filt_valid, 2))
		else $error("result without sample");
	flag_set_a: assert property (filt_valid && input_over_range
		|-> ##2 input_out_of_range_flag) else $error("range flag missing");
	flag_hold_a: assert property (!out_valid |-> $stable(input_out_of_range_flag))
		else $error("range flag moved");
	data_hold_a: assert property (!out_valid |-> $stable(out_data))
		else $error("result moved");
	framesync_bypass_a: assert property (out_valid && $past(format_select, 2)
		|-> out_data == $past(filt_data, 2)) else $error("correction in frame-sync");
	mode_pin_a: assert property ($past(aresetn)
		|-> high_res_mode == $past(resolution_mode_select)) else $error("mode pin not followed");
	clock_limit_a: assert property (!clk_in_range)
		else $error("clock limit wrong");
	cover property (out_valid && input_out_of_range_flag);
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && out_valid == 1'b0);
endmodule

bind aocm_top aocm_top_chk i_chk (.*);

//--- verification/aocm_top_tb.sv
// self-checking bench for the calibration block
module aocm_top_tb import aocm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [23:0] filt_data, out_data, ofs;
	logic [15:0] g;
	logic pend;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, filt_valid, input_over_range, resolution_mode_select;
	logic format_select, out_valid, input_out_of_range_flag, high_res_mode, clk_in_range;
	int n_fail, tests_run, cyc;
	aocm_top i_aocm_top (.*);
	aocm_host i_aocm_host (.*);
	initial begin
		aclk = 0;
		forever #25 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		i_aocm_host.wr(i, d, rs);
		chk(32'(rs), 32'(RESP_OKAY));
	endtask
	task automatic samp(input logic [23:0] d, input logic [23:0] e, input logic f);
		@(posedge aclk);
		filt_data <= d;
		filt_valid <= 1'b1;
		input_over_range <= f;
		@(posedge aclk);
		filt_valid <= 1'b0;
		filt_data <= ~d;
		input_over_range <= 1'b0;
		@(posedge aclk);
		#1;
		chk(32'(out_valid), 32'h1);
		chk(32'(out_data), 32'(e));
		// boundary event also counts toward the next result
		chk(32'(input_out_of_range_flag), 32'(f | pend));
		pend = f;
		@(posedge aclk);
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			tally_and_finish;
		end
	end
	initial begin
		{aresetn, filt_data, filt_valid, input_over_range, format_select, pend} = '0;
		resolution_mode_select = 1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		i_aocm_host.rd(IDX_GAIN_HI, v, rs);
		chk(v, 32'h80);
		i_aocm_host.rd(IDX_OFS_HIGH, v, rs);
		chk(v, 0);
		i_aocm_host.rd(IDX_STATUS, v, rs);
		chk(32'(v[3:0]), 32'h6);
		samp(24'h000100, 24'h000100, 0);
		$display("test reset done");
		samp(24'h00000E, 24'h00000E, 0);
		samp(24'h000012, 24'h000012, 0);
		ofs = i_aocm_host.ofs_avg(24'h00000E, 24'h000012);
		wr(IDX_OFS_LOW, {8'h0, ofs});
		wr(IDX_CONFIG, 32'h20);
		samp(24'h000100, 24'h0000F0, 1);
		g = i_aocm_host.gain_for(24'h78, 24'hF0);
		wr(IDX_GAIN_LOW, {24'h0, g[7:0]});
		wr(IDX_GAIN_HI, {24'h0, g[15:8]});
		samp(24'h000100, 24'h0000F0, 0);
		wr(IDX_CONFIG, 32'h30);
		samp(24'h000100, 24'h000078, 0);
		wr(IDX_GAIN_HI, 32'h0);
		samp(24'h000100, 24'h000000, 0);
		$display("test gain done");
		wr(IDX_CONFIG, 32'h20);
		wr(IDX_OFS_LOW, 32'h0);
		wr(IDX_OFS_HIGH, 32'h80);
		samp(24'h7FFFFF, 24'h7FFFFF, 0);
		wr(IDX_OFS_LOW, 32'hFF);
		wr(IDX_OFS_MID, 32'hFF);
		wr(IDX_OFS_HIGH, 32'h7F);
		samp(24'h800000, 24'h800000, 0);
		format_select <= 1'b1;
		samp(24'h000100, 24'h000100, 0);
		$display("test clip and format done");
		i_aocm_host.rd(IDX_RESULT, v, rs);
		chk(v, 32'h100);
		i_aocm_host.rd(6'h08, v, rs);
		chk(v, 0);
		chk(32'(rs), 32'(RESP_SLVERR));
		i_aocm_host.wr(IDX_STATUS, 32'hFF, rs);
		chk(32'(rs), 32'(RESP_SLVERR));
		resolution_mode_select <= 1'b0;
		i_aocm_host.rd(IDX_STATUS, v, rs);
		chk(32'(v[3:0]), 32'h0);
		$display("test registers done");
		tally_and_finish;
	end
endmodule
